// ===== rtl/ueh_pkg.sv
// Package for the unpredictable-encoding handler: decoded instruction carrier, classes and constants.
// Assumes an upstream decoder that classifies each instruction into the fields below.
package ueh_pkg;

	localparam int REG_PC       = 15;
	localparam int REG_SP       = 13;
	localparam int SP_LOW_BITS  = 2;
	localparam int FP_S_TOP     = 31;
	localparam int FP_D_TOP     = 15;
	localparam logic [31:0] SP_RESET = 32'h0000_0000;

	typedef enum logic [15:0] {
		UEH_OP_OTHER      = 16'h0001,
		UEH_OP_LDM        = 16'h0002,
		UEH_OP_STM        = 16'h0004,
		UEH_OP_FP_LDM     = 16'h0008,
		UEH_OP_FP_STM     = 16'h0010,
		UEH_OP_BCOND      = 16'h0020,
		UEH_OP_B          = 16'h0040,
		UEH_OP_BL         = 16'h0080,
		UEH_OP_BX         = 16'h0100,
		UEH_OP_BLX        = 16'h0200,
		UEH_OP_CMPBR      = 16'h0400,
		UEH_OP_TABLE_BR   = 16'h0800,
		UEH_OP_COND_START = 16'h1000,
		UEH_OP_PSTATE     = 16'h2000,
		UEH_OP_FP_DIRECT  = 16'h4000,
		UEH_OP_CUSTOM     = 16'h8000
	} ueh_op_t;

	typedef struct packed {
		logic        valid;
		ueh_op_t     op;
		logic        supported;
		logic        pc_bad;
		logic        sp_bad;
		logic        writeback;
		logic        is_load;
		logic        sp_write;
		logic        fp_double;
		logic [3:0]  base;
		logic [15:0] reg_list;
		logic [5:0]  fp_first;
		logic [5:0]  fp_count;
		logic [3:0]  continuation;
		logic        cont_altered;
		logic        branch_taken;
	} ueh_instr_t;

	typedef struct packed {
		logic        valid;
		logic        undefined_instruction_fault;
		logic        invalid_state_fault;
		logic        execute;
		logic        nop;
		logic        clear_cond_state;
		logic        stack_check;
		logic        store_initial_base;
		logic        base_unknown;
		logic [15:0] eff_list;
		logic [5:0]  fp_eff_count;
	} ueh_verdict_t;

	typedef enum logic [2:0] {
		UEH_ST_IDLE  = 3'h1,
		UEH_ST_ISSUE = 3'h2,
		UEH_ST_FAULT = 3'h4
	} ueh_state_t;

endpackage : ueh_pkg

// ===== rtl/ueh_sp_reg.sv
// Stack pointer storage whose two low bits read as zero and ignore writes.
// Assumes writes arrive from the execute stage on the core clock.
module ueh_sp_reg (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] rd_data
);

	typedef struct packed {
		logic [31:ueh_pkg::SP_LOW_BITS] sp;
	} ueh_sp_state_t;

	ueh_sp_state_t state;
	ueh_sp_state_t next_state;

	always_comb begin
		next_state = state;
		if (wr_en) begin
			next_state.sp = wr_data[31:ueh_pkg::SP_LOW_BITS];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state.sp <= ueh_pkg::SP_RESET[31:ueh_pkg::SP_LOW_BITS];
		end else begin
			state <= next_state;
		end
	end

	assign rd_data = {state.sp, {ueh_pkg::SP_LOW_BITS{1'b0}}};

endmodule : ueh_sp_reg

// ===== rtl/ueh_unpredictable_encoding_handler.sv
// Decode-stage checker: turns unpredictable encodings into a fault or a defined fallback.
// Assumes an upstream decoder supplies one classified instruction per valid cycle.
module ueh_unpredictable_encoding_handler (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire ueh_pkg::ueh_instr_t   instr,
	input  wire logic                  in_cond_block,
	input  wire logic                  fp_present,
	input  wire logic                  exception_stacking,
	input  wire logic                  sp_wr_en,
	input  wire logic [31:0]           sp_wr_data,
	output logic [31:0]                sp_value,
	output ueh_pkg::ueh_verdict_t      verdict,
	output logic                       misuse_trap,
	output logic                       cond_block_exit
);

	typedef struct packed {
		ueh_pkg::ueh_state_t   fsm;
		ueh_pkg::ueh_verdict_t out;
		logic                  clear_cond;
	} ueh_main_state_t;

	ueh_main_state_t state;
	ueh_main_state_t next_state;

	////////////////////////////////////////////////////////////////////////////////
	// Stack pointer storage.

	ueh_sp_reg ueh_sp_reg_inst (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (sp_wr_en),
		.wr_data (sp_wr_data),
		.rd_data (sp_value)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register list helpers.

	logic [4:0]  list_count;
	logic [15:0] below_base_mask;
	logic        base_in_list;
	logic        base_is_first;
	logic        pc_in_list;

	// Running count along the list, one small adder per register bit.
	logic [16:0][4:0] count_chain;

	assign count_chain[0] = 5'h00;

	for (genvar g = 0; g < 16; g++) begin : g_list_count
		assign count_chain[g + 1] = count_chain[g] + {4'h0, instr.reg_list[g]};
	end

	assign list_count = count_chain[16];

	// Bits strictly below the base register; base is first when none of them is listed.
	assign below_base_mask = (16'h0001 << instr.base) - 16'h0001;
	assign base_in_list    = instr.reg_list[instr.base];
	assign base_is_first   = base_in_list && ((instr.reg_list & below_base_mask) == 16'h0000);
	assign pc_in_list      = instr.reg_list[ueh_pkg::REG_PC];

	// Floating-point list trimmed to the implemented bank.
	logic [6:0] fp_end;
	logic [6:0] fp_limit;
	logic [5:0] fp_trim;

	always_comb begin
		fp_limit = instr.fp_double ? 7'(ueh_pkg::FP_D_TOP + 1) : 7'(ueh_pkg::FP_S_TOP + 1);
		fp_end   = {1'b0, instr.fp_first} + {1'b0, instr.fp_count};
		if ({1'b0, instr.fp_first} >= fp_limit) begin
			fp_trim = 6'h00;
		end else if (fp_end > fp_limit) begin
			fp_trim = 6'(fp_limit - {1'b0, instr.fp_first});
		end else begin
			fp_trim = instr.fp_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault classification.

	logic is_int_multi;
	logic is_fp_multi;
	logic undef_hit;
	logic inval_hit;
	logic cond_forbidden;

	assign is_int_multi = (instr.op == ueh_pkg::UEH_OP_LDM) || (instr.op == ueh_pkg::UEH_OP_STM);
	assign is_fp_multi  = (instr.op == ueh_pkg::UEH_OP_FP_LDM) || (instr.op == ueh_pkg::UEH_OP_FP_STM);

	always_comb begin
		cond_forbidden = 1'b0;
		if (in_cond_block) begin
			case (instr.op)
				ueh_pkg::UEH_OP_BCOND,
				ueh_pkg::UEH_OP_CMPBR,
				ueh_pkg::UEH_OP_COND_START,
				ueh_pkg::UEH_OP_PSTATE:     cond_forbidden = 1'b1;
				// Only the register-target exchange form is accepted by the decoder as BRANCH_LINK_EXCHANGE PC here.
				ueh_pkg::UEH_OP_BLX:        cond_forbidden = instr.pc_bad;
				ueh_pkg::UEH_OP_FP_DIRECT:  cond_forbidden = fp_present;
				ueh_pkg::UEH_OP_CUSTOM:     cond_forbidden = 1'b1;
				ueh_pkg::UEH_OP_B,
				ueh_pkg::UEH_OP_BL,
				ueh_pkg::UEH_OP_BX,
				ueh_pkg::UEH_OP_TABLE_BR:   cond_forbidden = 1'b0;
				default:                    cond_forbidden = 1'b0;
			endcase
		end
	end

	always_comb begin
		undef_hit = 1'b0;
		if (!instr.supported) begin
			undef_hit = 1'b1;
		end
		// Load multiple lists PC legitimately, so its PC flag is not taken as misuse.
		if (instr.pc_bad && (instr.op != ueh_pkg::UEH_OP_LDM)) begin
			undef_hit = 1'b1;
		end
		if (instr.sp_bad) begin
			undef_hit = 1'b1;
		end
		if ((instr.op == ueh_pkg::UEH_OP_STM) && pc_in_list) begin
			undef_hit = 1'b1;
		end
		if (cond_forbidden) begin
			undef_hit = 1'b1;
		end
	end

	always_comb begin
		inval_hit = 1'b0;
		if (is_int_multi && (instr.continuation != 4'h0)) begin
			// A restart that names an unlisted register cannot resume correctly.
			if (instr.cont_altered || !instr.reg_list[instr.continuation]) begin
				inval_hit = 1'b1;
			end
			if ((instr.op == ueh_pkg::UEH_OP_LDM) && base_in_list && (instr.continuation > instr.base)) begin
				inval_hit = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict register.

	always_comb begin
		next_state                 = state;
		next_state.out             = '0;
		next_state.clear_cond      = 1'b0;
		next_state.fsm             = ueh_pkg::UEH_ST_IDLE;
		case (state.fsm)
			ueh_pkg::UEH_ST_IDLE,
			ueh_pkg::UEH_ST_ISSUE,
			ueh_pkg::UEH_ST_FAULT: begin
				if (instr.valid) begin
					next_state.out.valid = 1'b1;
					// A fault suppresses execution so nothing architectural is touched.
					if (undef_hit) begin
						next_state.out.undefined_instruction_fault = 1'b1;
						next_state.fsm = ueh_pkg::UEH_ST_FAULT;
					end else if (inval_hit) begin
						next_state.out.invalid_state_fault = 1'b1;
						next_state.fsm = ueh_pkg::UEH_ST_FAULT;
					end else begin
						next_state.fsm = ueh_pkg::UEH_ST_ISSUE;
						next_state.out.execute = 1'b1;
						next_state.out.eff_list = instr.reg_list;
						if (is_int_multi && (list_count == 5'h00)) begin
							next_state.out.nop = 1'b1;
							next_state.out.execute = 1'b0;
						end
						if ((instr.op == ueh_pkg::UEH_OP_LDM) && pc_in_list && in_cond_block
							&& instr.branch_taken) begin
							next_state.clear_cond = 1'b1;
							next_state.out.clear_cond_state = 1'b1;
						end
						// Base writeback is dropped when the base is loaded.
						if ((instr.op == ueh_pkg::UEH_OP_LDM) && instr.writeback && base_in_list) begin
							next_state.out.store_initial_base = 1'b0;
						end
						if ((instr.op == ueh_pkg::UEH_OP_STM) && instr.writeback && base_is_first) begin
							next_state.out.store_initial_base = 1'b1;
						end
						if (is_fp_multi) begin
							next_state.out.fp_eff_count = fp_trim;
							next_state.out.base_unknown = instr.writeback && (fp_trim != instr.fp_count);
						end
						if (instr.sp_write && !instr.is_load) begin
							next_state.out.stack_check = 1'b1;
						end
					end
				end
				if (exception_stacking) begin
					next_state.out.stack_check = 1'b1;
				end
				if (instr.valid && instr.sp_write && instr.is_load && !exception_stacking) begin
					next_state.out.stack_check = 1'b0;
				end
			end
			default: begin
				next_state.fsm = ueh_pkg::UEH_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state.fsm        <= ueh_pkg::UEH_ST_IDLE;
			state.out        <= '0;
			state.clear_cond <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign verdict         = state.out;
	assign misuse_trap     = state.out.undefined_instruction_fault | state.out.invalid_state_fault;
	assign cond_block_exit = state.clear_cond;

endmodule : ueh_unpredictable_encoding_handler

// ===== verification/ueh_chk.sv
// Concurrent checks on the ports of the unpredictable-encoding handler.
// Assumes verdict and trap outputs are registered one cycle after the instruction.
module ueh_chk (
	input wire logic                  clk,
	input wire logic                  reset,
	input wire ueh_pkg::ueh_instr_t   instr,
	input wire logic                  in_cond_block,
	input wire logic                  fp_present,
	input wire logic                  exception_stacking,
	input wire logic                  sp_wr_en,
	input wire logic [31:0]           sp_wr_data,
	input wire logic [31:0]           sp_value,
	input wire ueh_pkg::ueh_verdict_t verdict,
	input wire logic                  misuse_trap,
	input wire logic                  cond_block_exit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge clk); endclocking
	default disable iff (reset);
	logic ok;
	logic multi_register_load;
	logic multi_register_store;
	logic udf;
	// Clean instruction: any fault it gets must come from the rule under test.
	assign ok = instr.valid && instr.supported && !instr.pc_bad && !instr.sp_bad;
	assign multi_register_load = instr.op == ueh_pkg::UEH_OP_LDM;
	assign multi_register_store = instr.op == ueh_pkg::UEH_OP_STM;
	assign udf = verdict.undefined_instruction_fault;
	//////////////////////////////////////////////////////////////////////////////
	AST_SP_WRITE: assert property (sp_wr_en |=> sp_value == ($past(sp_wr_data) & 32'hFFFF_FFFC))
		else $error("sp low bits");
	AST_UNSUPPORTED: assert property (instr.valid && !instr.supported |=> udf)
		else $error("unsupported");
	AST_PC_OPERAND: assert property (instr.valid && instr.pc_bad && !multi_register_load |=> udf)
		else $error("pc operand");
	AST_SP_OPERAND: assert property (instr.valid && instr.sp_bad |=> udf)
		else $error("sp operand");
	AST_STORE_PC: assert property (instr.valid && multi_register_store && instr.reg_list[15] |=> udf && !verdict.execute)
		else $error("store pc");
	AST_LOAD_PC_BLOCK: assert property (ok && multi_register_load && instr.continuation == 4'h0 && instr.reg_list[15]
		&& in_cond_block |=> !misuse_trap ##0 cond_block_exit == $past(instr.branch_taken))
		else $error("load pc block");
	AST_BLOCK_TRAP: assert property (instr.valid && in_cond_block
		&& (instr.op & 16'hB420) != 16'h0000 |=> udf)
		else $error("block trap");
	AST_FP_BLOCK: assert property (instr.valid && in_cond_block && fp_present
		&& instr.op == ueh_pkg::UEH_OP_FP_DIRECT |=> udf)
		else $error("fp block");
	AST_STACK_ENTRY: assert property (exception_stacking |=> verdict.stack_check)
		else $error("stacking check");
	AST_SP_LOAD: assert property (instr.valid && instr.is_load && !exception_stacking
		|=> !verdict.stack_check)
		else $error("sp load check");
	AST_CONT_BASE: assert property (ok && multi_register_load && instr.reg_list[instr.base]
		&& instr.continuation > instr.base |=> verdict.invalid_state_fault)
		else $error("continuation");
	AST_TRAP_SUM: assert property (instr.valid
		|=> verdict.valid && misuse_trap == (udf || verdict.invalid_state_fault))
		else $error("trap sum");
	cover property (cond_block_exit);
	cover property (verdict.invalid_state_fault);
	cover property (verdict.nop);
endmodule : ueh_chk

bind ueh_unpredictable_encoding_handler ueh_chk ueh_chk_inst (.clk(clk), .reset(reset), .instr(instr),
	.in_cond_block(in_cond_block), .fp_present(fp_present), .exception_stacking(exception_stacking),
	.sp_wr_en(sp_wr_en), .sp_wr_data(sp_wr_data), .sp_value(sp_value), .verdict(verdict),
	.misuse_trap(misuse_trap), .cond_block_exit(cond_block_exit));

// ===== verification/testbench.sv
// Self-checking bench for the unpredictable-encoding handler: random and corner-case instructions.
// Assumes the handler stands alone, answering one cycle after each instruction.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t mismatch", $time); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk, reset, cb, fp, es, we, trap, cbx;
	logic [31:0]           wd, spv, sp_exp;
	ueh_pkg::ueh_instr_t   i;
	ueh_pkg::ueh_verdict_t v;
	int                    n_errors, n_checks, seed;

	ueh_unpredictable_encoding_handler ueh_unpredictable_encoding_handler_inst (.clk(clk), .reset(reset),
		.instr(i), .in_cond_block(cb), .fp_present(fp), .exception_stacking(es), .sp_wr_en(we),
		.sp_wr_data(wd), .sp_value(spv), .verdict(v), .misuse_trap(trap), .cond_block_exit(cbx));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic eu(ueh_pkg::ueh_instr_t x, logic b, logic f);
		// Mask B420 holds the classes that always trap inside a conditional block.
		return !x.supported || x.sp_bad || (x.pc_bad && x.op != ueh_pkg::UEH_OP_LDM)
			|| (x.op == ueh_pkg::UEH_OP_STM && x.reg_list[15])
			|| (b && ((x.op & 16'hB420) != 16'h0000 || (f && x.op == ueh_pkg::UEH_OP_FP_DIRECT)));
	endfunction : eu

	function automatic logic ei(ueh_pkg::ueh_instr_t x);
		return x.continuation != 4'h0 && (x.cont_altered || !x.reg_list[x.continuation]
			|| (x.op == ueh_pkg::UEH_OP_LDM && x.reg_list[x.base] && x.continuation > x.base));
	endfunction : ei

	function automatic ueh_pkg::ueh_instr_t mk(ueh_pkg::ueh_op_t o, logic [15:0] l);
		mk = '0;
		mk.valid = 1'b1;
		mk.supported = 1'b1;
		mk.op = o;
		mk.reg_list = l;
		mk.fp_count = 6'h01;
	endfunction : mk

	// Every call drives one instruction and checks its verdict, so calls run back to back.
	task automatic step(ueh_pkg::ueh_instr_t x, logic b, logic f, logic s);
		logic        u;
		logic        n;
		logic        e;
		logic        z;
		logic [31:0] w;
		u = eu(x, b, f);
		n = !u && ei(x);
		z = x.op inside {ueh_pkg::UEH_OP_LDM, ueh_pkg::UEH_OP_STM} && x.reg_list == 16'h0000;
		w = $random(seed);
		// Bit 0 never reaches the stack pointer, so it is free to pick the write strobe.
		e = w[0];
		if (e) begin
			sp_exp = w & 32'hFFFF_FFFC;
		end
		i = x;
		cb = b;
		fp = f;
		es = s;
		we = e;
		wd = w;
		@(posedge clk);
		#1;
		`CHK(spv, sp_exp)
		if (x.valid) begin
			`CHK(v.valid, 1'b1)
			`CHK(v.undefined_instruction_fault, u)
			`CHK(v.invalid_state_fault, n)
			`CHK(trap, u | n)
			`CHK(v.execute, !(u | n | z))
			`CHK(v.nop, !(u | n) && z)
			`CHK(v.stack_check, s | (!(u | n) & x.sp_write & !x.is_load))
			`CHK(cbx, !(u | n) && b && x.op == ueh_pkg::UEH_OP_LDM && x.reg_list[15] && x.branch_taken)
		end
	endtask : step

	task test_done;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		test_done();
	end

	initial begin
		ueh_pkg::ueh_instr_t x;
		logic [63:0]         r;
		n_errors = 0;
		n_checks = 0;
		seed = 32'hD6A0;
		sp_exp = ueh_pkg::SP_RESET;
		{i, cb, fp, es, we, wd} = '0;
		reset = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		`CHK(trap, 1'b0)
		reset = 1'b0;
		`CHK(spv, ueh_pkg::SP_RESET)
		for (int k = 0; k < 400; k++) begin
			r = {$random(seed), $random(seed)};
			x = r[$bits(x)-1:0];
			x.valid = 1'b1;
			x.op = ueh_pkg::ueh_op_t'(16'h0001 << r[63:60]);
			x.supported = r[0] | r[1];
			x.pc_bad = &r[4:2];
			x.sp_bad = &r[7:5];
			x.cont_altered &= r[8];
			x.fp_count[0] = 1'b1;
			if (!(x.op inside {ueh_pkg::UEH_OP_LDM, ueh_pkg::UEH_OP_STM}))
				x.continuation = 4'h0;
			step(x, r[9], r[10], r[11] & r[12]);
		end
		step(mk(ueh_pkg::UEH_OP_STM, 16'h8001), 1'b0, 1'b0, 1'b0);
		step(mk(ueh_pkg::UEH_OP_LDM, 16'h0000), 1'b1, 1'b0, 1'b0);
		`CHK(v.nop, 1'b1)
		x = mk(ueh_pkg::UEH_OP_LDM, 16'h8003);
		x.branch_taken = 1'b1;
		step(x, 1'b1, 1'b0, 1'b0);
		`CHK(cbx, 1'b1)
		`CHK(v.clear_cond_state, 1'b1)
		x = mk(ueh_pkg::UEH_OP_LDM, 16'h0012);
		x.writeback = 1'b1;
		x.base = 4'h1;
		step(x, 1'b0, 1'b0, 1'b0);
		`CHK(v.eff_list, 16'h0012)
		for (int b = 1; b < 5; b += 3) begin
			x.op = ueh_pkg::UEH_OP_STM;
			x.base = 4'(b);
			step(x, 1'b0, 1'b0, 1'b0);
			`CHK(v.store_initial_base, b == 1)
		end
		for (int d = 0; d < 2; d++) begin
			x = mk(ueh_pkg::UEH_OP_FP_LDM, 16'h0000);
			x.writeback = 1'b1;
			x.fp_double = d[0];
			x.fp_first = d[0] ? 6'h0E : 6'h1E;
			x.fp_count = 6'h04;
			step(x, 1'b0, 1'b0, 1'b0);
			`CHK(v.fp_eff_count, 6'h02)
			`CHK(v.base_unknown, 1'b1)
		end
		x = mk(ueh_pkg::UEH_OP_LDM, 16'h0036);
		x.base = 4'h2;
		x.continuation = 4'h4;
		step(x, 1'b0, 1'b0, 1'b0);
		x.base = 4'h4;
		x.continuation = 4'h2;
		step(x, 1'b0, 1'b0, 1'b0);
		x.continuation = 4'h3;
		step(x, 1'b0, 1'b0, 1'b0);
		for (int j = 0; j < 32; j++)
			step(mk(ueh_pkg::ueh_op_t'(16'h0001 << j[3:0]), 16'h0001), 1'b1, j[4], 1'b0);
		for (int k = 0; k < 3; k++) begin
			x = mk(ueh_pkg::UEH_OP_OTHER, 16'h0000);
			x.sp_write = 1'b1;
			x.is_load = k > 0;
			step(x, 1'b0, 1'b0, k == 2);
			`CHK(v.stack_check, k != 1)
		end
		test_done();
	end
endmodule : testbench
